//--- core/opm_pkg.sv
/*
  Constants and types shared by the output pin multiplexer.
  Assumes a 32-bit AXI4-Lite register bus; register byte address is four times its index.
*/
package opm_pkg;

  // ==========================================================
  // Register bus
  localparam int AddrW = 8;
  localparam int DataW = 32;
  localparam int IdxLsb = 2;
  localparam int IdxW = 6;
  localparam logic [IdxW-1:0] IdxSrcSel = 6'h0C;
  localparam logic [IdxW-1:0] IdxLatchSet = 6'h0E;
  localparam logic [IdxW-1:0] IdxLatchClr = 6'h0F;
  localparam logic [IdxW-1:0] IdxRtsCtl = 6'h10;
  localparam logic [IdxW-1:0] IdxStatus = 6'h11;
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] SrcSelReset = 8'h00;
  localparam logic [7:0] LatchReset = 8'h00;
  localparam logic [3:0] RtsCtlReset = 4'h0;

  // ==========================================================
  // Source select fields
  localparam int SelPin7 = 7;
  localparam int SelPin6 = 6;
  localparam int SelPin5 = 5;
  localparam int SelPin4 = 4;
  localparam int SelPin3Lsb = 2;
  localparam int SelPin2Lsb = 0;
  localparam logic [1:0] Pin3Latch = 2'h0;
  localparam logic [1:0] Pin3Timer = 2'h1;
  localparam logic [1:0] Pin3TxClkB = 2'h2;
  localparam logic [1:0] Pin3RxClkB = 2'h3;
  localparam logic [1:0] Pin2Latch = 2'h0;
  localparam logic [1:0] Pin2TxClkAOver = 2'h1;
  localparam logic [1:0] Pin2TxClkA = 2'h2;
  localparam logic [1:0] Pin2RxClkA = 2'h3;

  // ==========================================================
  // Request-to-send control fields
  localparam int RtsRxA = 0;
  localparam int RtsTxA = 1;
  localparam int RtsRxB = 2;
  localparam int RtsTxB = 3;

  // ==========================================================
  // Status fields and pin masks of the reduced and full variants
  localparam int StatLatchLsb = 0;
  localparam int StatPinLsb = 8;
  localparam int StatRtsLsb = 16;
  localparam logic [7:0] ReducedPinMask = 8'h03;
  localparam logic [7:0] FullPinMask = 8'hFF;

  // ==========================================================
  // Pin drive kinds
  typedef enum logic [2:0] {
    OPM_DRV_LATCH = 3'b001,
    OPM_DRV_PUSH = 3'b010,
    OPM_DRV_OD = 3'b100
  } opm_drive_e;

endpackage : opm_pkg

//--- core/opm_sync2.sv
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs arrive from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module opm_sync2 #(
  parameter int Width = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [Width-1:0] asyncIn,
  output logic [Width-1:0] syncOut
);

  logic [Width-1:0] firstQ;
  logic [Width-1:0] firstD;
  logic [Width-1:0] secondQ;
  logic [Width-1:0] secondD;

  // ==========================================================
  // Two stages
  always_comb begin
    firstD = asyncIn;
    secondD = firstQ;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      firstQ <= '0;
      secondQ <= '0;
    end else begin
      firstQ <= firstD;
      secondQ <= secondD;
    end
  end

  assign syncOut = secondQ;

endmodule : opm_sync2

`default_nettype wire

//--- core/opm_pin_drive.sv
/*
  Registered driver of one output pin: latch level, push-pull or open-drain.
  Assumes drive kind and sources come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module opm_pin_drive (
  input wire logic clock,
  input wire logic rst,
  input wire opm_pkg::opm_drive_e mode,
  input wire logic latchBit,
  input wire logic altSig,
  output logic pinOut,
  output logic pinOeN
);

  logic outQ;
  logic outD;
  logic oeNQ;
  logic oeND;

  // ==========================================================
  // Drive selection
  always_comb begin
    unique case (mode)
      opm_pkg::OPM_DRV_LATCH: begin
        outD = ~latchBit;
        oeND = 1'b0;
      end
      opm_pkg::OPM_DRV_PUSH: begin
        outD = altSig;
        oeND = 1'b0;
      end
      opm_pkg::OPM_DRV_OD: begin
        outD = 1'b0;
        oeND = ~altSig;
      end
      default: begin
        outD = 1'b1;
        oeND = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outQ <= 1'b1;
      oeNQ <= 1'b0;
    end else begin
      outQ <= outD;
      oeNQ <= oeND;
    end
  end

  assign pinOut = outQ;
  assign pinOeN = oeNQ;

endmodule : opm_pin_drive

`default_nettype wire

//--- core/opm_output_port_mux.sv
/*
  Output pin multiplexer with its AXI4-Lite register slave.
  Assumes channel, timer and clock sources are on the same clock; pin levels are not.
*/
// What this block does
// - Pin 7 shows inverted latch bit 7, or channel B transmit room open-drain.
// - Pin 6 shows inverted latch bit 6, or channel A transmit room open-drain.
// - Pin 5 shows inverted latch bit 5, or channel B receive indication open-drain.
// - Pin 4 shows inverted latch bit 4, or channel A receive indication open-drain.
// - Select bits 3:2 pick pin 3: latch, timer, B transmit or receive clock.
// - Pin 3 carrying the timer output is driven open-drain.
// - Select bits 1:0 pick pin 2: latch, A oversampled, bit transmit or receive clock.
// - Pins 0 and 1 take request-to-send role when either mode bit is set.
// - Pin 0 carries channel A request, pin 1 channel B, both active low.
// - Source select affects only pins 7 to 2, never pins 0 and 1.
// - Reduced variant has pins 0 and 1 only, as latch or request-to-send; pins 2 and up are driven high in reset, released after.
// - A general-purpose pin shows the complement of its latch bit.
// - Set command sets latch bits where data is one; clear command clears them.
// - Reset clears the latch, so general-purpose pins leave reset high.
`timescale 1ns/1ps
`default_nettype none

module opm_output_port_mux #(
  parameter bit ReducedPins = 1'b0,
  parameter int PinCount = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [opm_pkg::AddrW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [opm_pkg::DataW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [opm_pkg::AddrW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [opm_pkg::DataW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic requestSendA,
  input wire logic requestSendB,
  input wire logic txRoomA,
  input wire logic txRoomB,
  input wire logic rxAvailOrFullA,
  input wire logic rxAvailOrFullB,
  input wire logic txClkAOversampled,
  input wire logic txClkABitrate,
  input wire logic rxClkABitrate,
  input wire logic txClkBBitrate,
  input wire logic rxClkBBitrate,
  input wire logic timerOut,
  input wire logic [PinCount-1:0] outPinIn,
  output logic [PinCount-1:0] outPinOut,
  output logic [PinCount-1:0] outPinOeN
);

  // ==========================================================
  // Declarations
  localparam logic [7:0] PinMask = ReducedPins ? opm_pkg::ReducedPinMask : opm_pkg::FullPinMask;

  logic [7:0] srcSelQ;
  logic [7:0] srcSelD;
  logic [7:0] outputLatchQ;
  logic [7:0] outputLatchD;
  logic [3:0] rtsCtlQ;
  logic [3:0] rtsCtlD;

  logic awHeldQ;
  logic awHeldD;
  logic [opm_pkg::AddrW-1:0] awAddrQ;
  logic [opm_pkg::AddrW-1:0] awAddrD;
  logic wHeldQ;
  logic wHeldD;
  logic [opm_pkg::DataW-1:0] wDataQ;
  logic [opm_pkg::DataW-1:0] wDataD;
  logic [3:0] wStrbQ;
  logic [3:0] wStrbD;
  logic bValidQ;
  logic bValidD;
  logic [1:0] bRespQ;
  logic [1:0] bRespD;
  logic rValidQ;
  logic rValidD;
  logic [1:0] rRespQ;
  logic [1:0] rRespD;
  logic [opm_pkg::DataW-1:0] rDataQ;
  logic [opm_pkg::DataW-1:0] rDataD;

  logic doWrite;
  logic [opm_pkg::IdxW-1:0] wrIdx;
  logic [opm_pkg::IdxW-1:0] rdIdx;
  logic [7:0] wrByte;
  logic [PinCount-1:0] pinLevel;
  logic requestSendAN;
  logic requestSendBN;
  logic rtsRoleA;
  logic rtsRoleB;
  logic [1:0] pin3Sel;
  logic [1:0] pin2Sel;

  opm_pkg::opm_drive_e pinMode [PinCount];
  logic [PinCount-1:0] pinAlt;

  // ==========================================================
  // Write channel handshake
  assign s_axi_awready = ~awHeldQ & ~bValidQ;
  assign s_axi_wready = ~wHeldQ & ~bValidQ;
  assign doWrite = awHeldQ & wHeldQ & ~bValidQ;
  assign wrIdx = awAddrQ[opm_pkg::IdxLsb +: opm_pkg::IdxW];
  assign wrByte = wStrbQ[0] ? wDataQ[7:0] : 8'h00;

  always_comb begin
    awHeldD = awHeldQ;
    awAddrD = awAddrQ;
    wHeldD = wHeldQ;
    wDataD = wDataQ;
    wStrbD = wStrbQ;
    bValidD = bValidQ;
    bRespD = bRespQ;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeldD = 1'b1;
      awAddrD = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeldD = 1'b1;
      wDataD = s_axi_wdata;
      wStrbD = s_axi_wstrb;
    end
    if (doWrite) begin
      awHeldD = 1'b0;
      wHeldD = 1'b0;
      bValidD = 1'b1;
      unique case (wrIdx)
        opm_pkg::IdxSrcSel, opm_pkg::IdxLatchSet, opm_pkg::IdxLatchClr,
        opm_pkg::IdxRtsCtl, opm_pkg::IdxStatus: bRespD = opm_pkg::RespOkay;
        default: bRespD = opm_pkg::RespSlvErr;
      endcase
    end else if (bValidQ && s_axi_bready) begin
      bValidD = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= 4'h0;
      bValidQ <= 1'b0;
      bRespQ <= opm_pkg::RespOkay;
    end else begin
      awHeldQ <= awHeldD;
      awAddrQ <= awAddrD;
      wHeldQ <= wHeldD;
      wDataQ <= wDataD;
      wStrbQ <= wStrbD;
      bValidQ <= bValidD;
      bRespQ <= bRespD;
    end
  end

  assign s_axi_bvalid = bValidQ;
  assign s_axi_bresp = bRespQ;

  // ==========================================================
  // Control registers and output latch
  always_comb begin
    srcSelD = srcSelQ;
    rtsCtlD = rtsCtlQ;
    outputLatchD = outputLatchQ;
    if (doWrite) begin
      if (wrIdx == opm_pkg::IdxSrcSel) begin
        srcSelD = wrByte;
      end
      if (wrIdx == opm_pkg::IdxRtsCtl) begin
        rtsCtlD = wrByte[3:0];
      end
      if (wrIdx == opm_pkg::IdxLatchSet) begin
        outputLatchD = outputLatchQ | (wrByte & PinMask);
      end
      if (wrIdx == opm_pkg::IdxLatchClr) begin
        outputLatchD = outputLatchQ & ~(wrByte & PinMask);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      srcSelQ <= opm_pkg::SrcSelReset;
      rtsCtlQ <= opm_pkg::RtsCtlReset;
      outputLatchQ <= opm_pkg::LatchReset;
    end else begin
      srcSelQ <= srcSelD;
      rtsCtlQ <= rtsCtlD;
      outputLatchQ <= outputLatchD;
    end
  end

  // ==========================================================
  // Read channel
  assign s_axi_arready = ~rValidQ;
  assign rdIdx = s_axi_araddr[opm_pkg::IdxLsb +: opm_pkg::IdxW];

  always_comb begin
    rValidD = rValidQ;
    rRespD = rRespQ;
    rDataD = rDataQ;
    if (s_axi_arvalid && s_axi_arready) begin
      rValidD = 1'b1;
      rRespD = opm_pkg::RespOkay;
      rDataD = '0;
      unique case (rdIdx)
        opm_pkg::IdxSrcSel, opm_pkg::IdxLatchSet, opm_pkg::IdxLatchClr: rDataD = '0;
        opm_pkg::IdxRtsCtl: rDataD[3:0] = rtsCtlQ;
        opm_pkg::IdxStatus: begin
          rDataD[opm_pkg::StatLatchLsb +: 8] = outputLatchQ;
          rDataD[opm_pkg::StatPinLsb +: 8] = pinLevel;
          rDataD[opm_pkg::StatRtsLsb +: 2] = {rtsRoleB, rtsRoleA};
        end
        default: rRespD = opm_pkg::RespSlvErr;
      endcase
    end else if (rValidQ && s_axi_rready) begin
      rValidD = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rValidQ <= 1'b0;
      rRespQ <= opm_pkg::RespOkay;
      rDataQ <= '0;
    end else begin
      rValidQ <= rValidD;
      rRespQ <= rRespD;
      rDataQ <= rDataD;
    end
  end

  assign s_axi_rvalid = rValidQ;
  assign s_axi_rresp = rRespQ;
  assign s_axi_rdata = rDataQ;

  // ==========================================================
  // Pin level readback
  opm_sync2 #(
    .Width(PinCount)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn(outPinIn),
    .syncOut(pinLevel)
  );

  // ==========================================================
  // Source selection
  assign requestSendAN = ~requestSendA;
  assign requestSendBN = ~requestSendB;
  assign rtsRoleA = rtsCtlQ[opm_pkg::RtsRxA] | rtsCtlQ[opm_pkg::RtsTxA];
  assign rtsRoleB = rtsCtlQ[opm_pkg::RtsRxB] | rtsCtlQ[opm_pkg::RtsTxB];
  assign pin3Sel = srcSelQ[opm_pkg::SelPin3Lsb +: 2];
  assign pin2Sel = srcSelQ[opm_pkg::SelPin2Lsb +: 2];

  always_comb begin
    pinAlt = '0;
    // Pins 0 and 1 look only at the mode bits
    pinMode[0] = rtsRoleA ? opm_pkg::OPM_DRV_PUSH : opm_pkg::OPM_DRV_LATCH;
    pinAlt[0] = requestSendAN;
    pinMode[1] = rtsRoleB ? opm_pkg::OPM_DRV_PUSH : opm_pkg::OPM_DRV_LATCH;
    pinAlt[1] = requestSendBN;
    unique case (pin2Sel)
      opm_pkg::Pin2Latch: pinMode[2] = opm_pkg::OPM_DRV_LATCH;
      default: pinMode[2] = opm_pkg::OPM_DRV_PUSH;
    endcase
    unique case (pin2Sel)
      opm_pkg::Pin2TxClkAOver: pinAlt[2] = txClkAOversampled;
      opm_pkg::Pin2TxClkA: pinAlt[2] = txClkABitrate;
      opm_pkg::Pin2RxClkA: pinAlt[2] = rxClkABitrate;
      default: pinAlt[2] = 1'b0;
    endcase
    unique case (pin3Sel)
      opm_pkg::Pin3Latch: pinMode[3] = opm_pkg::OPM_DRV_LATCH;
      opm_pkg::Pin3Timer: pinMode[3] = opm_pkg::OPM_DRV_OD;
      default: pinMode[3] = opm_pkg::OPM_DRV_PUSH;
    endcase
    unique case (pin3Sel)
      opm_pkg::Pin3Timer: pinAlt[3] = timerOut;
      opm_pkg::Pin3TxClkB: pinAlt[3] = txClkBBitrate;
      opm_pkg::Pin3RxClkB: pinAlt[3] = rxClkBBitrate;
      default: pinAlt[3] = 1'b0;
    endcase
    pinMode[4] = srcSelQ[opm_pkg::SelPin4] ? opm_pkg::OPM_DRV_OD : opm_pkg::OPM_DRV_LATCH;
    pinAlt[4] = rxAvailOrFullA;
    pinMode[5] = srcSelQ[opm_pkg::SelPin5] ? opm_pkg::OPM_DRV_OD : opm_pkg::OPM_DRV_LATCH;
    pinAlt[5] = rxAvailOrFullB;
    pinMode[6] = srcSelQ[opm_pkg::SelPin6] ? opm_pkg::OPM_DRV_OD : opm_pkg::OPM_DRV_LATCH;
    pinAlt[6] = txRoomA;
    pinMode[7] = srcSelQ[opm_pkg::SelPin7] ? opm_pkg::OPM_DRV_OD : opm_pkg::OPM_DRV_LATCH;
    pinAlt[7] = txRoomB;
    // Absent pins of the reduced variant stay released
    for (int i = 2; i < PinCount; i++) begin
      if (!PinMask[i]) begin
        pinMode[i] = opm_pkg::OPM_DRV_OD;
        pinAlt[i] = 1'b0;
      end
    end
  end

  // ==========================================================
  // Pin drivers
  for (genvar g = 0; g < PinCount; g++) begin : g_pin
    opm_pin_drive u_drive (
      .clock(clock),
      .rst(rst),
      .mode(pinMode[g]),
      .latchBit(outputLatchQ[g]),
      .altSig(pinAlt[g]),
      .pinOut(outPinOut[g]),
      .pinOeN(outPinOeN[g])
    );
  end

endmodule : opm_output_port_mux

`default_nettype wire

//--- testbench/opm_asserts.sv
/*
  Port checker for the output pin multiplexer.
  Assumes binding to opm_output_port_mux and a bus master holding bready high.
*/
`timescale 1ns/1ps
`default_nettype none

module opm_asserts #(
  parameter int PinCount = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic requestSendA,
  input wire logic txRoomA,
  input wire logic txRoomB,
  input wire logic rxAvailOrFullA,
  input wire logic rxAvailOrFullB,
  input wire logic txClkAOversampled,
  input wire logic txClkBBitrate,
  input wire logic timerOut,
  input wire logic [PinCount-1:0] outPinOut,
  input wire logic [PinCount-1:0] outPinOeN
);
  // ==========================================================
  // Register shadows
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] sel_q;
  logic [7:0] lat_q;
  logic [3:0] rts_q;
  logic quiet_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q <= 8'h00;
      data_q <= 8'h00;
      sel_q <= 8'h00;
      lat_q <= 8'h00;
      rts_q <= 4'h0;
      quiet_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) addr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) data_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      quiet_q <= !s_axi_bvalid;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0) begin
        if (addr_q == 8'h30) sel_q <= data_q;
        if (addr_q == 8'h38) lat_q <= lat_q | data_q;
        if (addr_q == 8'h3C) lat_q <= lat_q & ~data_q;
        if (addr_q == 8'h40) rts_q <= data_q[3:0];
      end
    end
  end

  // ==========================================================
  // Pin checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pin7_room: assert property (quiet_q && sel_q[7] |->
    !outPinOut[7] && outPinOeN[7] == !$past(txRoomB)) else $error("pin 7 alternate wrong");
  a_pin6_room: assert property (quiet_q && sel_q[6] |->
    !outPinOut[6] && outPinOeN[6] == !$past(txRoomA)) else $error("pin 6 alternate wrong");
  a_pin5_rx: assert property (quiet_q && sel_q[5] |->
    !outPinOut[5] && outPinOeN[5] == !$past(rxAvailOrFullB)) else $error("pin 5 alternate wrong");
  a_pin4_rx: assert property (quiet_q && sel_q[4] |->
    !outPinOut[4] && outPinOeN[4] == !$past(rxAvailOrFullA)) else $error("pin 4 alternate wrong");
  a_pin3_timer: assert property (quiet_q && sel_q[3:2] == 2'h1 |->
    !outPinOut[3] && outPinOeN[3] == !$past(timerOut)) else $error("pin 3 timer wrong");
  a_pin3_clock: assert property (quiet_q && sel_q[3:2] == 2'h2 |->
    outPinOut[3] == $past(txClkBBitrate) && !outPinOeN[3]) else $error("pin 3 clock wrong");
  a_pin2_over: assert property (quiet_q && sel_q[1:0] == 2'h1 |->
    outPinOut[2] == $past(txClkAOversampled) && !outPinOeN[2]) else $error("pin 2 clock wrong");
  a_rts_pin0: assert property (quiet_q && |rts_q[1:0] |->
    outPinOut[0] == !$past(requestSendA) && !outPinOeN[0]) else $error("pin 0 request wrong");
  a_gp_low: assert property (quiet_q && rts_q == 4'h0 |->
    outPinOut[1:0] == ~lat_q[1:0] && outPinOeN[1:0] == 2'h0) else $error("pins 1:0 wrong");
  a_gp_high: assert property (quiet_q && sel_q[7:4] == 4'h0 |->
    outPinOut[7:4] == ~lat_q[7:4] && outPinOeN[7:4] == 4'h0) else $error("pins 7:4 wrong");

  c_room: cover property (quiet_q && sel_q[7] && !outPinOeN[7]);
  c_rts: cover property (quiet_q && |rts_q[1:0] && !outPinOut[0]);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : opm_asserts

bind opm_output_port_mux opm_asserts #(.PinCount(PinCount)) u_chk (
  .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .requestSendA(requestSendA),
  .txRoomA(txRoomA), .txRoomB(txRoomB), .rxAvailOrFullA(rxAvailOrFullA),
  .rxAvailOrFullB(rxAvailOrFullB), .txClkAOversampled(txClkAOversampled),
  .txClkBBitrate(txClkBBitrate), .timerOut(timerOut), .outPinOut(outPinOut),
  .outPinOeN(outPinOeN)
);

`default_nettype wire

//--- testbench/opm_far_side.sv
/*
  External pin wiring: one pull-up on every output pin.
  Assumes active-low output enables from the multiplexer.
*/
`timescale 1ns/1ps
`default_nettype none

module opm_far_side #(
  parameter int PinCount = 8
) (
  input wire logic [PinCount-1:0] pinOut,
  input wire logic [PinCount-1:0] pinOeN,
  output logic [PinCount-1:0] pinLevel
);
  // ==========================================================
  // Released pins read high through the pull-up
  assign pinLevel = pinOut | pinOeN;
endmodule : opm_far_side

`default_nettype wire

//--- testbench/tb_output_port_function_mux.sv
/*
  Self-checking bench for the output pin multiplexer.
  Assumes the pull-up wiring model and an AXI4-Lite master in this module.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_output_port_function_mux;
  // ==========================================================
  // Signals
  logic clock = 1'b0;
  logic rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pinOut, pinOeN, pinWire;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] src;
  logic [3:0] strb;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int ind[4] = '{4, 5, 2, 3};
  int p3[4] = '{0, 11, 9, 10};
  int p2[4] = '{0, 6, 7, 8};

  always #12.5 clock = ~clock;

  opm_output_port_mux dut (
    .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .requestSendA(src[0]),
    .requestSendB(src[1]), .txRoomA(src[2]), .txRoomB(src[3]), .rxAvailOrFullA(src[4]),
    .rxAvailOrFullB(src[5]), .txClkAOversampled(src[6]), .txClkABitrate(src[7]),
    .rxClkABitrate(src[8]), .txClkBBitrate(src[9]), .rxClkBBitrate(src[10]),
    .timerOut(src[11]), .outPinIn(pinWire), .outPinOut(pinOut), .outPinOeN(pinOeN)
  );

  opm_far_side far (.pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinWire));

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clock);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clock);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge clock); while (!s_axi_bvalid);
    chk("write response", s_axi_bresp, er);
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!t) begin
      @(negedge clock);
      t = s_axi_arready;
      @(posedge clock);
    end
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, 2'h0);
    settle();
  endtask : put

  task automatic drv(input logic [11:0] x);
    @(posedge clock);
    src <= x;
    settle();
  endtask : drv

  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    logic [11:0] oh;
    rst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    src = 12'h000;
    strb = 4'hF;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    settle();
    chk("pins after reset", pinWire, 8'hFF);
    chk("enables after reset", pinOeN, 8'h00);
    rd(8'h44, rdData, resp);
    chk("status after reset", rdData, 32'h0000FF00);
    rd(8'h40, rdData, resp);
    chk("request control reset", rdData, 32'h0);
    put(8'h38, 8'hF0);
    chk("pins after set", pinWire, 8'h0F);
    put(8'h38, 8'h00);
    chk("pins after empty set", pinWire, 8'h0F);
    put(8'h3C, 8'h30);
    chk("pins after clear", pinWire, 8'h3F);
    rd(8'h44, rdData, resp);
    chk("latch in status", rdData[7:0], 8'hC0);
    put(8'h30, 8'hFF);
    chk("alternates idle", pinWire, 8'hF3);
    for (int i = 0; i < 4; i++) begin
      drv(12'(1 << ind[i]));
      chk("open-drain pin", pinWire, 8'hF3 & ~(8'h10 << i));
    end
    for (int k = 0; k < 4; k++) begin
      for (int lv = 0; lv < 2; lv++) begin
        put(8'h30, {4'h0, 2'(k), 2'(k)});
        oh = (k == 0) ? 12'h000 : 12'(1 << p3[k]) | 12'(1 << p2[k]);
        drv(lv ? oh : ~oh);
        chk("pin 3 source", pinWire[3], (k == 0) ? 1 : (k == 1) ? !lv : lv);
        chk("pin 2 source", pinWire[2], (k == 0) ? 1 : lv);
      end
    end
    for (int j = 0; j < 4; j++) begin
      put(8'h40, 8'h01 << j);
      drv(12'h003);
      chk("request pins", pinWire[1:0], (j < 2) ? 2'b10 : 2'b01);
      rd(8'h44, rdData, resp);
      chk("request role", rdData[17:16], (j < 2) ? 2'b01 : 2'b10);
    end
    drv(12'h001);
    chk("request idle", pinWire[1:0], 2'b11);
    rd(8'h40, rdData, resp);
    chk("request control readback", rdData, 32'h8);
    put(8'h40, 8'h00);
    put(8'h38, 8'h03);
    chk("general pins low", pinWire[1:0], 2'b00);
    @(posedge clock);
    strb <= 4'h0;
    put(8'h38, 8'hFF);
    chk("masked set", pinWire[7:4], 4'h3);
    @(posedge clock);
    strb <= 4'hF;
    wr(8'h04, 8'hFF, 2'h2);
    rd(8'h04, rdData, resp);
    chk("unmapped read response", resp, 2'h2);
    chk("unmapped read data", rdData, 32'h0);
    rd(8'h30, rdData, resp);
    chk("select reads zero", rdData, 32'h0);
    summarize();
  end
endmodule : tb_output_port_function_mux

`default_nettype wire
